/* File: src/rtseq_top.sv */
// Reset timeout sequencer: delay stages, reset-cause flags, register file
//
// Functional notes
// - After power-on release, run the power-up delay, then the oscillator count.
// - Total delay follows oscillator mode and delay disable bit, power-up and brown-out.
// - External-clock mode with delay disabled: no delay, reset released directly.
// - RC, external-clock, internal modes: delay only if enabled, never an oscillator count.
// - Delay stages run from the power-on pulse regardless of the reset pin.
// - Stages already expired: execution starts as soon as the pin goes high.
// - Reset-cause register, bit 0 active-low brown-out flag, unknown after power-on.
// - A brown-out reset clears the brown-out flag to 0.
// - With brown-out enable 00 the brown-out flag value is unspecified.
// - Bit 1 power-on flag forced 0 on power-on, unchanged on other resets.
// - Power-up delay is nominal 64 ms from low-frequency oscillator, power-on or brown-out.
// - Delay disable bit set disables the power-up delay, cleared enables it.
// - Brown-out enable 11 always active, 10 active except sleep, 0x disabled.
`timescale 1ns/10ps
module rtseq_top #(
    parameter int POWER_UP_DELAY_TIMER_TICKS  = rtseq_pkg::POWER_UP_DELAY_TIMER_TICKS,
    parameter int OST_PERIODS = rtseq_pkg::OST_PERIODS
) (
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [7:0]  S_AXI_AWADDR_IN,
    input  wire logic        S_AXI_AWVALID_IN,
    output logic             S_AXI_AWREADY_OUT,
    input  wire logic [31:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]  S_AXI_WSTRB_IN,
    input  wire logic        S_AXI_WVALID_IN,
    output logic             S_AXI_WREADY_OUT,
    output logic [1:0]       S_AXI_BRESP_OUT,
    output logic             S_AXI_BVALID_OUT,
    input  wire logic        S_AXI_BREADY_IN,
    input  wire logic [7:0]  S_AXI_ARADDR_IN,
    input  wire logic        S_AXI_ARVALID_IN,
    output logic             S_AXI_ARREADY_OUT,
    output logic [31:0]      S_AXI_RDATA_OUT,
    output logic [1:0]       S_AXI_RRESP_OUT,
    output logic             S_AXI_RVALID_OUT,
    input  wire logic        S_AXI_RREADY_IN,
    input  wire logic        POR_RELEASED_IN,
    input  wire logic        BROWNOUT_DET_IN,
    input  wire logic        EXTERNAL_RESET_PIN_N_IN,
    input  wire logic        SLEEP_IN,
    input  wire logic        WAKE_IN,
    input  wire logic        LF_OSC_IN,
    input  wire logic        MAIN_OSC_IN,
    output logic             INT_RESET_OUT,
    output logic             CORE_HOLD_OUT,
    output logic             IRQ_OUT
);
    typedef enum logic [2:0] {
        ST_HOLD, ST_POWER_UP_DELAY_TIMER, ST_OST, ST_PIN, ST_RUN, ST_SLEEP
    } rtseq_state_t;

    localparam int NSYNC = 5;

    rtseq_reg_if regs ();

    rtseq_state_t                state;
    rtseq_state_t                next_state;
    logic                        waking;
    logic                        next_waking;
    logic                        brownout_flag;
    logic                        power_on_flag;
    logic [rtseq_pkg::EV_COUNT-1:0] istat;
    logic [rtseq_pkg::EV_COUNT-1:0] imask;
    logic [5:0]                  config_reg;
    logic [NSYNC-1:0]            sync_a;
    logic [NSYNC-1:0]            sync_b;
    logic                        power_up_delay_timer_done;
    logic                        ost_done;

    // Address match, used by both the read mux and the write strobes
    function automatic logic rtseq_hit(input logic [7:0] addr, input logic [7:0] off);
        rtseq_hit = (addr[7:2] == off[7:2]);
    endfunction

    // Pins and detector levels come from outside the clock domain
    wire [NSYNC-1:0] raw_pins = {WAKE_IN, SLEEP_IN, EXTERNAL_RESET_PIN_N_IN,
                                 BROWNOUT_DET_IN, POR_RELEASED_IN};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_pins[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    wire por_ok   = sync_b[0];
    wire bor_det  = sync_b[1];
    wire pin_high = sync_b[2];
    wire sleep_rq = sync_b[3];
    wire wake_rq  = sync_b[4];

    // Configuration fields
    wire [2:0] osc_mode  = config_reg[rtseq_pkg::CFG_MODE_LSB +: 3];
    wire       pud_off   = config_reg[rtseq_pkg::CFG_PUD_BIT];
    wire [1:0] bor_field = config_reg[rtseq_pkg::CFG_BOR_LSB +: 2];
    wire       crystal   = (osc_mode == rtseq_pkg::LOW_POWER_CRYSTAL_MODE)
                        || (osc_mode == rtseq_pkg::CRYSTAL_MODE)
                        || (osc_mode == rtseq_pkg::HIGH_SPEED_CRYSTAL_MODE);

    // Brown-out detection gating by the enable field
    wire bor_active = (bor_field == rtseq_pkg::BOR_ALWAYS)
                   || (bor_field == rtseq_pkg::BOR_NOT_SLEEP && state != ST_SLEEP);
    wire bor_trip    = bor_det && bor_active;
    wire power_event = !por_ok || bor_trip;

    // Stage that follows the held phase, picked from mode and disable bit
    wire [2:0] after_hold = !pud_off ? 3'(ST_POWER_UP_DELAY_TIMER)
                          : crystal  ? 3'(ST_OST)
                          :            3'(ST_PIN);

    // Sequencing; the pin gates the final release and pulls run or sleep back to ST_PIN, never the stages
    always_comb begin
        next_state  = state;
        next_waking = waking;
        case (state)
            ST_HOLD: begin
                if (!power_event) begin
                    next_state  = rtseq_state_t'(after_hold);
                    next_waking = 1'b0;
                end
            end
            ST_POWER_UP_DELAY_TIMER: begin
                if (power_up_delay_timer_done) begin
                    next_state = crystal ? ST_OST : ST_PIN;
                end
            end
            ST_OST: begin
                if (ost_done) begin
                    next_state  = waking ? ST_RUN : ST_PIN;
                    next_waking = 1'b0;
                end
            end
            ST_PIN: begin
                if (pin_high) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!pin_high) begin
                    next_state = ST_PIN;
                end else if (sleep_rq) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!pin_high) begin
                    next_state = ST_PIN;
                end else if (wake_rq) begin
                    next_state  = crystal ? ST_OST : ST_RUN;
                    next_waking = crystal;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
        // Any new supply event restarts the whole sequence
        if (power_event) begin
            next_state  = ST_HOLD;
            next_waking = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state  <= ST_HOLD;
            waking <= 1'b0;
        end else begin
            state  <= next_state;
            waking <= next_waking;
        end
    end

    // Stage timers on the low-frequency and main oscillators; stages ignore the pin
    rtseq_tick_counter #(.W(rtseq_pkg::CNT_W)) u_power_up_delay_timer (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .run_in   (state == ST_POWER_UP_DELAY_TIMER),
        .src_in   (LF_OSC_IN),
        .limit_in (rtseq_pkg::CNT_W'(POWER_UP_DELAY_TIMER_TICKS)),
        .done_out (power_up_delay_timer_done)
    );

    rtseq_tick_counter #(.W(rtseq_pkg::CNT_W)) u_ost (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .run_in   (state == ST_OST),
        .src_in   (MAIN_OSC_IN),
        .limit_in (rtseq_pkg::CNT_W'(OST_PERIODS)),
        .done_out (ost_done)
    );

    // Core outputs; a wake-up count stalls the core without resetting it
    assign INT_RESET_OUT = (state == ST_HOLD) || (state == ST_POWER_UP_DELAY_TIMER) || (state == ST_PIN)
                        || (state == ST_OST && !waking);
    assign CORE_HOLD_OUT = (state != ST_RUN);
    assign IRQ_OUT       = |(istat & imask);

    // Events that set sticky interrupt status bits
    wire in_op = (state == ST_RUN) || (state == ST_SLEEP);
    wire [rtseq_pkg::EV_COUNT-1:0] events;
    assign events[rtseq_pkg::EV_POWER_ON] = !por_ok && state != ST_HOLD;
    assign events[rtseq_pkg::EV_BROWNOUT] = por_ok && bor_trip && state != ST_HOLD;
    assign events[rtseq_pkg::EV_RELEASE]  = (next_state == ST_RUN) && (state != ST_RUN)
                                         && (state != ST_SLEEP);
    assign events[rtseq_pkg::EV_PIN]      = in_op && !pin_high && !power_event;

    // Write strobes
    wire [7:0] wbyte     = regs.wr_data[7:0];
    wire       wr_cause  = regs.wr_en && regs.wr_lane0
                        && rtseq_hit(regs.wr_addr, rtseq_pkg::REG_CAUSE_OFF);
    wire       wr_istat  = regs.wr_en && regs.wr_lane0
                        && rtseq_hit(regs.wr_addr, rtseq_pkg::REG_ISTAT_OFF);
    wire       wr_imask  = regs.wr_en && regs.wr_lane0
                        && rtseq_hit(regs.wr_addr, rtseq_pkg::REG_IMASK_OFF);
    wire       wr_config = regs.wr_en && regs.wr_lane0
                        && rtseq_hit(regs.wr_addr, rtseq_pkg::REG_CONFIG_OFF);

    // Reset-cause flags: hardware forcing wins over a software write
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            brownout_flag <= rtseq_pkg::CAUSE_RESET[rtseq_pkg::BROWNOUT_FLAG_BIT];
            power_on_flag <= rtseq_pkg::CAUSE_RESET[rtseq_pkg::POWER_ON_FLAG_BIT];
        end else begin
            if (!por_ok) begin
                power_on_flag <= 1'b0;
            end else if (wr_cause) begin
                power_on_flag <= wbyte[rtseq_pkg::POWER_ON_FLAG_BIT];
            end
            // A disabled detector never trips, so the flag is left to software
            if (por_ok && bor_trip) begin
                brownout_flag <= 1'b0;
            end else if (wr_cause) begin
                brownout_flag <= wbyte[rtseq_pkg::BROWNOUT_FLAG_BIT];
            end
        end
    end

    // Interrupt status (write one to clear, set wins), mask and configuration
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            istat      <= rtseq_pkg::ISTAT_RESET;
            imask      <= rtseq_pkg::IMASK_RESET;
            config_reg <= rtseq_pkg::CONFIG_RESET;
        end else begin
            istat <= (istat & ~(wr_istat ? wbyte[rtseq_pkg::EV_COUNT-1:0] : 4'h0)) | events;
            if (wr_imask) begin
                imask <= wbyte[rtseq_pkg::EV_COUNT-1:0];
            end
            if (wr_config) begin
                config_reg <= wbyte[5:0];
            end
        end
    end

    // Read decode; unmapped addresses answer with an error and zero data
    wire [7:0] ra    = regs.rd_addr;
    wire       r_cau = rtseq_hit(ra, rtseq_pkg::REG_CAUSE_OFF);
    wire       r_ist = rtseq_hit(ra, rtseq_pkg::REG_ISTAT_OFF);
    wire       r_imk = rtseq_hit(ra, rtseq_pkg::REG_IMASK_OFF);
    wire       r_cfg = rtseq_hit(ra, rtseq_pkg::REG_CONFIG_OFF);
    wire       r_seq = rtseq_hit(ra, rtseq_pkg::REG_SEQ_OFF);
    wire [7:0] seq_view = {4'h0, INT_RESET_OUT, 3'(state)};

    assign regs.rd_ok   = r_cau || r_ist || r_imk || r_cfg || r_seq;
    assign regs.rd_data = r_cau ? {30'h0, power_on_flag, brownout_flag}
                        : r_ist ? {28'h0, istat}
                        : r_imk ? {28'h0, imask}
                        : r_cfg ? {26'h0, config_reg}
                        : r_seq ? {24'h0, seq_view}
                        :         32'h0000_0000;
    assign regs.wr_ok   = rtseq_hit(regs.wr_addr, rtseq_pkg::REG_CAUSE_OFF)
                       || rtseq_hit(regs.wr_addr, rtseq_pkg::REG_ISTAT_OFF)
                       || rtseq_hit(regs.wr_addr, rtseq_pkg::REG_IMASK_OFF)
                       || rtseq_hit(regs.wr_addr, rtseq_pkg::REG_CONFIG_OFF)
                       || rtseq_hit(regs.wr_addr, rtseq_pkg::REG_SEQ_OFF);

    rtseq_axil_slave u_axil (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .awaddr_in   (S_AXI_AWADDR_IN),
        .awvalid_in  (S_AXI_AWVALID_IN),
        .awready_out (S_AXI_AWREADY_OUT),
        .wdata_in    (S_AXI_WDATA_IN),
        .wstrb_in    (S_AXI_WSTRB_IN),
        .wvalid_in   (S_AXI_WVALID_IN),
        .wready_out  (S_AXI_WREADY_OUT),
        .bresp_out   (S_AXI_BRESP_OUT),
        .bvalid_out  (S_AXI_BVALID_OUT),
        .bready_in   (S_AXI_BREADY_IN),
        .araddr_in   (S_AXI_ARADDR_IN),
        .arvalid_in  (S_AXI_ARVALID_IN),
        .arready_out (S_AXI_ARREADY_OUT),
        .rdata_out   (S_AXI_RDATA_OUT),
        .rresp_out   (S_AXI_RRESP_OUT),
        .rvalid_out  (S_AXI_RVALID_OUT),
        .rready_in   (S_AXI_RREADY_IN),
        .regs        (regs.bus)
    );
endmodule

/* File: src/rtseq_pkg.sv */
// Constants shared by the reset timeout sequencer modules
package rtseq_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] REG_CAUSE_OFF  = 8'h00;
    localparam logic [7:0] REG_ISTAT_OFF  = 8'h04;
    localparam logic [7:0] REG_IMASK_OFF  = 8'h08;
    localparam logic [7:0] REG_CONFIG_OFF = 8'h0c;
    localparam logic [7:0] REG_SEQ_OFF    = 8'h10;

    // Reset-cause register fields
    localparam int BROWNOUT_FLAG_BIT = 0;
    localparam int POWER_ON_FLAG_BIT = 1;
    localparam logic [1:0] CAUSE_RESET = 2'h0;

    // Configuration register fields and value after reset
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_PUD_BIT  = 3;
    localparam int CFG_BOR_LSB  = 4;
    localparam logic [5:0] CONFIG_RESET = 6'h30;

    // Oscillator mode codes held in the configuration register
    localparam logic [2:0] LOW_POWER_CRYSTAL_MODE  = 3'h0;
    localparam logic [2:0] CRYSTAL_MODE            = 3'h1;
    localparam logic [2:0] HIGH_SPEED_CRYSTAL_MODE = 3'h2;
    localparam logic [2:0] RESISTOR_CAPACITOR_MODE = 3'h3;
    localparam logic [2:0] EXTERNAL_CLOCK_MODE     = 3'h4;
    localparam logic [2:0] INTERNAL_OSCILLATOR_MODE = 3'h5;

    // Brown-out enable field codes
    localparam logic [1:0] BOR_ALWAYS    = 2'h3;
    localparam logic [1:0] BOR_NOT_SLEEP = 2'h2;

    // Interrupt status bit positions
    localparam int EV_POWER_ON = 0;
    localparam int EV_BROWNOUT = 1;
    localparam int EV_RELEASE  = 2;
    localparam int EV_PIN      = 3;
    localparam int EV_COUNT    = 4;
    localparam logic [3:0] ISTAT_RESET = 4'h0;
    localparam logic [3:0] IMASK_RESET = 4'h0;

    // Delay timing: power-up delay from the low-frequency oscillator
    localparam int POWER_UP_DELAY_PERIOD_MS = 64;
    localparam int LF_OSC_KHZ               = 31;
    localparam int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_PERIOD_MS * LF_OSC_KHZ;
    localparam int OST_PERIODS = 1024;
    localparam int CNT_W = 12;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: src/rtseq_reg_if.sv */
// Register access carrier between the bus slave and the register file
`timescale 1ns/10ps
interface rtseq_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        wr_lane0;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport bus  (output wr_en, wr_addr, wr_data, wr_lane0, rd_addr,
                  input  wr_ok, rd_data, rd_ok);
    modport regs (input  wr_en, wr_addr, wr_data, wr_lane0, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

/* File: src/rtseq_tick_counter.sv */
// Counts rising edges of a foreign slow clock after a two-flop synchroniser
`timescale 1ns/10ps
module rtseq_tick_counter #(
    parameter int W = 12
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         run_in,
    input  wire logic         src_in,
    input  wire logic [W-1:0] limit_in,
    output logic              done_out
);
    logic         sync_a;
    logic         sync_b;
    logic         sync_c;
    logic [W-1:0] count;
    wire          edge_seen = sync_b & ~sync_c;

    // Synchroniser plus one stage for edge detection
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= src_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Count only while the stage runs; leaving it clears the count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
        end else if (!run_in) begin
            count <= '0;
        end else if (edge_seen && !done_out) begin
            count <= count + 1'b1;
        end
    end

    assign done_out = run_in && (count == limit_in);
endmodule

/* File: src/rtseq_axil_slave.sv */
// AXI4-Lite slave handshakes feeding the register carrier
`timescale 1ns/10ps
module rtseq_axil_slave (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    input  wire logic [7:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    rtseq_reg_if.bus         regs
);
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_lane0;

    // Channels are blocked while a response is pending, one write at a time
    assign awready_out   = !aw_held && !bvalid_out;
    assign wready_out    = !w_held && !bvalid_out;
    assign arready_out   = !rvalid_out;
    assign regs.wr_en    = aw_held && w_held;
    assign regs.wr_addr  = aw_addr;
    assign regs.wr_data  = w_data;
    assign regs.wr_lane0 = w_lane0;
    assign regs.rd_addr  = araddr_in;

    // Write path: address and data taken in either order
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            aw_addr    <= 8'h00;
            w_data     <= 32'h0000_0000;
            w_lane0    <= 1'b0;
            bvalid_out <= 1'b0;
            bresp_out  <= rtseq_pkg::RESP_OKAY;
        end else begin
            if (awvalid_in && awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr_in;
            end
            if (wvalid_in && wready_out) begin
                w_held  <= 1'b1;
                w_data  <= wdata_in;
                w_lane0 <= wstrb_in[0];
            end
            if (regs.wr_en) begin
                aw_held    <= 1'b0;
                w_held     <= 1'b0;
                bvalid_out <= 1'b1;
                bresp_out  <= regs.wr_ok ? rtseq_pkg::RESP_OKAY : rtseq_pkg::RESP_SLVERR;
            end else if (bvalid_out && bready_in) begin
                bvalid_out <= 1'b0;
            end
        end
    end

    // Read path: data captured at the address handshake
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
            rdata_out  <= 32'h0000_0000;
            rresp_out  <= rtseq_pkg::RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            rvalid_out <= 1'b1;
            rdata_out  <= regs.rd_data;
            rresp_out  <= regs.rd_ok ? rtseq_pkg::RESP_OKAY : rtseq_pkg::RESP_SLVERR;
        end else if (rvalid_out && rready_in) begin
            rvalid_out <= 1'b0;
        end
    end
endmodule

/* File: tb/rtseq_osc_model.sv */
// Free-running slow and main oscillator sources
`timescale 1ns/10ps
module rtseq_osc_model (
    output logic lf_out,
    output logic main_out
);
    // Phases unrelated to the system clock; the sequencer synchronises both
    initial lf_out = 1'b0;
    initial main_out = 1'b0;
    always #140 lf_out = ~lf_out;
    always #83 main_out = ~main_out;
endmodule

/* File: tb/rtseq_top_sva.sv */
// Port-level assertions for the reset timeout sequencer
`timescale 1ns/10ps
module rtseq_top_sva #(
    parameter int POWER_UP_DELAY_TIMER_TICKS  = 4,
    parameter int OST_PERIODS = 4
) (
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        S_AXI_AWVALID_IN,
    input wire logic        S_AXI_AWREADY_OUT,
    input wire logic        S_AXI_WVALID_IN,
    input wire logic        S_AXI_WREADY_OUT,
    input wire logic        S_AXI_BVALID_OUT,
    input wire logic        S_AXI_BREADY_IN,
    input wire logic        S_AXI_ARVALID_IN,
    input wire logic        S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic        S_AXI_RVALID_OUT,
    input wire logic        S_AXI_RREADY_IN,
    input wire logic        POR_RELEASED_IN,
    input wire logic        EXTERNAL_RESET_PIN_N_IN,
    input wire logic        INT_RESET_OUT,
    input wire logic        CORE_HOLD_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Supply loss wins over every state within the synchroniser delay
    AST_POWER_LOSS: assert property (!POR_RELEASED_IN |-> ##[1:4] INT_RESET_OUT)
        else $error("internal reset missing after power loss");
    AST_POWER_UP_HOLD: assert property ($rose(POR_RELEASED_IN) |-> INT_RESET_OUT[*3])
        else $error("internal reset released too early");
    AST_PIN_RELEASE: assert property ($fell(INT_RESET_OUT) |-> $past(EXTERNAL_RESET_PIN_N_IN, 3))
        else $error("reset released while pin low");
    AST_CORE_HOLD: assert property (INT_RESET_OUT |-> CORE_HOLD_OUT)
        else $error("core running during reset");
    // Bus answers: fixed latencies and responses held until accepted
    AST_WRITE_ANSWER: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
        && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT) else $error("write response late");
    AST_READ_ANSWER: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read response late");
    AST_WRITE_HOLD: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped");
    AST_READ_HOLD: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data not held");
    cover property ($fell(INT_RESET_OUT));
    cover property ($rose(POR_RELEASED_IN));
    cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
endmodule
bind rtseq_top rtseq_top_sva #(.POWER_UP_DELAY_TIMER_TICKS(POWER_UP_DELAY_TIMER_TICKS), .OST_PERIODS(OST_PERIODS)) u_sva (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
    .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WVALID_IN(S_AXI_WVALID_IN),
    .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .POR_RELEASED_IN(POR_RELEASED_IN), .EXTERNAL_RESET_PIN_N_IN(EXTERNAL_RESET_PIN_N_IN),
    .INT_RESET_OUT(INT_RESET_OUT), .CORE_HOLD_OUT(CORE_HOLD_OUT));

/* File: tb/reset_timeout_sequencer_tb_top.sv */
// Self-checking bench: registers, release timing per mode, reset-cause flags
`timescale 1ns/10ps
module reset_timeout_sequencer_tb_top;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, slp = 0, wk = 0;
    logic        por = 0, bor = 0, pin = 1, lf, mo, awr, wrdy, bv, arr, rv, irq, ires;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, v;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0, total_checks = 0, seed = 89, n;
    always #5 clk = ~clk;
    rtseq_osc_model u_osc (.lf_out(lf), .main_out(mo));
    // Short delay counts keep each power cycle to a few hundred clocks
    rtseq_top #(.POWER_UP_DELAY_TIMER_TICKS(4), .OST_PERIODS(4)) u_dut (.CLK_IN(clk), .RST_IN(rst),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
        .S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .POR_RELEASED_IN(por),
        .BROWNOUT_DET_IN(bor), .EXTERNAL_RESET_PIN_N_IN(pin), .SLEEP_IN(slp),
        .WAKE_IN(wk), .LF_OSC_IN(lf), .MAIN_OSC_IN(mo), .INT_RESET_OUT(ires),
        .CORE_HOLD_OUT(), .IRQ_OUT(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bready is raised only after bvalid is seen, so the held-response case is exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        chk(bresp, 2'h0);
        bre <= 1'b1;
        @(posedge clk);
        bre <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b1;
        @(posedge clk);
        rre <= 1'b0;
        chk(rd, e);
        chk(rresp, r);
    endtask
    // Counts clocks until internal reset drops, capped at 400
    task automatic settle;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ires !== 1'b0 && n < 400);
    endtask
    task automatic pc(input logic brown);
        bor <= brown;
        por <= brown;
        repeat (4) @(posedge clk);
        bor <= 1'b0;
        por <= 1'b1;
        settle();
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(8'h0c, 32'h30, 2'h0);
        rc(8'h00, 32'h0, 2'h0);
        rc(8'h24, 32'h0, 2'h2);
        // Release time classes: none, oscillator count, power-up delay, both
        for (int m = 0; m < 12; m++) begin
            wr(8'h0c, {26'h0, 2'h3, m[0], m[3:1]});
            pc(1'b0);
            v = (n >= 25) + (n >= 80) + (n >= 130);
            chk(v, (m[0] ? 0 : 2) + (m < 6));
        end
        v = $random(seed) & 32'h3;
        wr(8'h00, v);
        rc(8'h00, v, 2'h0);
        wr(8'h00, 32'h3);
        pc(1'b1);
        rc(8'h00, 32'h2, 2'h0);
        pc(1'b0);
        rc(8'h00, 32'h0, 2'h0);
        wr(8'h0c, 32'h0);
        bor <= 1'b1;
        repeat (8) @(posedge clk);
        bor <= 1'b0;
        rc(8'h10, 32'h4, 2'h0);
        pin <= 1'b0;
        pc(1'b0);
        chk(n, 400);
        rc(8'h10, 32'hb, 2'h0);
        pin <= 1'b1;
        settle();
        chk(n <= 5, 1);
        chk(irq, 0);
        wr(8'h08, 32'h4);
        chk(irq, 1);
        wr(8'h04, 32'hf);
        chk(irq, 0);
        wr(8'h0c, 32'h20);
        slp <= 1'b1;
        repeat (4) @(posedge clk);
        bor <= 1'b1;
        repeat (4) @(posedge clk);
        bor <= 1'b0;
        rc(8'h10, 32'h5, 2'h0);
        wk <= 1'b1;
        repeat (8) @(posedge clk);
        rc(8'h10, 32'h2, 2'h0);
        print_verdict();
    end
    // The scenarios need about 2000 clocks; this limit leaves a wide margin
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
